/* File: hw/sleep_clk_pkg.sv */
package sleep_clk_pkg;

    // ************************************************************
    // divider
    // ************************************************************
    localparam int unsigned CNT_W            = 8;
    localparam logic [3:0]  DIV_RESET        = 4'h0;
    localparam logic [3:0]  DIV_MAX_LEGAL    = 4'h8;
    localparam logic [7:0]  CNT_RESET        = 8'h00;

    // ************************************************************
    // sleep mode select codes
    // ************************************************************
    localparam logic [2:0]  MODE_IDLE        = 3'h0;
    localparam logic [2:0]  MODE_ADC_NR      = 3'h1;
    localparam logic [2:0]  MODE_PDOWN       = 3'h2;
    localparam logic [2:0]  MODE_PSAVE       = 3'h3;
    localparam logic [2:0]  MODE_STANDBY     = 3'h6;
    localparam logic [2:0]  MODE_RESET       = 3'h0;

    // ************************************************************
    // wake timing, in master clock cycles
    // ************************************************************
    localparam logic [7:0]  STALL_CYC        = 8'h04;
    localparam logic [7:0]  STANDBY_WAKE_CYC = 8'h06;
    // oscillator restart from power-down/save; figure is fixed here at 16 cycles
    localparam logic [7:0]  PDOWN_WAKE_CYC   = 8'h10;
    localparam logic [7:0]  RUNNING_WAKE_CYC = 8'h00;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP,
        ST_START,
        ST_HOLD
    } power_state_e;

endpackage : sleep_clk_pkg

/* File: hw/sleep_mode_clock_gating.sv */
`timescale 1ns/1ps
// Behaviour
// - divider switches glitch-free, never faster
// - free counter on master clock, count hidden
// - new rate after one old-rate edge
// - sleep only when permit bit set
// - wake stalls four cycles past start-up
// - state kept intact across sleep
// - reset while asleep wakes to reset vector
// - codes 000 idle, 001 adc, 010 power-down
// - code 011 power-save, async timer wakes
// - code 110 standby, oscillator on, six cycles
// - idle stops cpu and flash clocks only
// - idle wakes on any enabled interrupt
// - adc mode stops io, cpu, flash clocks
// - adc mode wakes only on listed sources
// - idle or adc mode starts conversion
// - power-down halts all clocks and oscillator
// - power-down wakes on reset, serial, external_irq_line_zero, pins
// - line zero wakes deep modes only level-sensed
// - timer oscillator kept only when asynchronous
module sleep_mode_clock_gating
    import sleep_clk_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_div_wr,
    input  wire logic [3:0] i_clock_divide_select,
    input  wire logic       i_sleep_exec,
    input  wire logic       i_sleep_permit_bit,
    input  wire logic [2:0] i_sleep_mode_select,
    input  wire logic       i_ext_crystal,
    input  wire logic       i_comparator_power_off,
    input  wire logic       i_timer_async,
    input  wire logic       i_adc_enable,
    input  wire logic       i_reset_req,
    input  wire logic       i_irq_line_zero,
    input  wire logic       i_line_zero_level,
    input  wire logic       i_irq_pin_change,
    input  wire logic       i_irq_serial_start,
    input  wire logic       i_irq_timer,
    input  wire logic       i_irq_mem_ready,
    input  wire logic       i_irq_adc_done,
    input  wire logic       i_irq_comparator,
    input  wire logic       i_irq_other_io,
    output logic            o_sys_clk_en,
    output logic [3:0]      o_div_applied,
    output logic            o_cpu_clk_en,
    output logic            o_flash_clk_en,
    output logic            o_io_clk_en,
    output logic            o_adc_clk_en,
    output logic            o_async_clk_en,
    output logic            o_main_osc_en,
    output logic            o_timer_osc_en,
    output logic            o_cpu_stall,
    output logic            o_asleep,
    output logic            o_adc_start,
    output logic            o_wake_irq,
    output logic            o_wake_reset,
    output logic            o_sleep_nop
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [3:0]       div;
        logic [3:0]       pend_div;
        logic             pend;
        logic             tick;
        power_state_e     st;
        logic [2:0]       mode;
        logic [7:0]       wait_cnt;
        logic             cpu_en;
        logic             flash_en;
        logic             io_en;
        logic             adc_en;
        logic             asy_en;
        logic             osc_en;
        logic             tosc_en;
        logic             stall;
        logic             asleep;
        logic             adc_start;
        logic             wake_irq;
        logic             wake_rst;
        logic             nop;
    } gate_state_s;

    gate_state_s s_q;
    gate_state_s s_d;

    function automatic logic [CNT_W-1:0] div_mask(input logic [3:0] dv);
        logic [CNT_W:0] m;
        m = (9'h001 << dv) - 9'h001;
        return m[CNT_W-1:0];
    endfunction : div_mask

    function automatic logic mode_legal(input logic [2:0] md, input logic xtal);
        return (md == MODE_IDLE) || (md == MODE_ADC_NR) || (md == MODE_PDOWN)
             || (md == MODE_PSAVE) || ((md == MODE_STANDBY) && xtal);
    endfunction : mode_legal

    logic [CNT_W-1:0] cnt_mask;
    logic             wake_ok;
    logic             line0_deep;

    assign cnt_mask   = div_mask(s_q.div);
    assign line0_deep = i_irq_line_zero && i_line_zero_level;

    // ************************************************************
    // wake source filter per mode
    // ************************************************************
    always_comb begin
        wake_ok = 1'b0;
        unique case (s_q.mode)
            MODE_IDLE: begin
                wake_ok = i_irq_line_zero || i_irq_pin_change || i_irq_serial_start
                          || i_irq_timer || i_irq_mem_ready || i_irq_adc_done
                          || i_irq_other_io
                          || (i_irq_comparator && !i_comparator_power_off);
            end
            MODE_ADC_NR: begin
                wake_ok = i_irq_adc_done || line0_deep || i_irq_pin_change
                          || i_irq_serial_start || i_irq_mem_ready
                          || (i_irq_timer && i_timer_async);
            end
            MODE_PSAVE: begin
                wake_ok = line0_deep || i_irq_pin_change || i_irq_serial_start
                          || (i_irq_timer && i_timer_async);
            end
            default: begin
                // power-down and standby
                wake_ok = line0_deep || i_irq_pin_change || i_irq_serial_start;
            end
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d           = s_q;
        s_d.adc_start = 1'b0;
        s_d.wake_irq  = 1'b0;
        s_d.wake_rst  = 1'b0;
        s_d.nop       = 1'b0;

        // the counter is never reset on a write; the switch waits for an old-rate
        // edge so no short period appears
        s_d.cnt = s_q.cnt + 8'h01;
        if (i_div_wr && (i_clock_divide_select <= DIV_MAX_LEGAL)) begin
            s_d.pend_div = i_clock_divide_select;
            s_d.pend     = 1'b1;
        end
        s_d.tick = ((s_q.cnt & cnt_mask) == cnt_mask);
        if (s_d.tick && s_q.pend && !(i_div_wr && (i_clock_divide_select <= DIV_MAX_LEGAL))) begin
            // edge one at the old rate, then restart counting at the new rate
            s_d.div  = s_q.pend_div;
            s_d.pend = 1'b0;
            s_d.cnt  = CNT_RESET;
        end

        unique case (s_q.st)
            ST_RUN: begin
                if (i_sleep_exec) begin
                    if (i_sleep_permit_bit && mode_legal(i_sleep_mode_select, i_ext_crystal)) begin
                        s_d.st       = ST_SLEEP;
                        s_d.mode     = i_sleep_mode_select;
                        s_d.asleep   = 1'b1;
                        s_d.stall    = 1'b1;
                        // only enables drop; no state is cleared, so register
                        // file and sram hold their contents
                        s_d.cpu_en   = 1'b0;
                        s_d.flash_en = 1'b0;
                        s_d.io_en    = (i_sleep_mode_select == MODE_IDLE);
                        s_d.adc_en   = (i_sleep_mode_select == MODE_IDLE)
                                       || (i_sleep_mode_select == MODE_ADC_NR);
                        s_d.asy_en   = (i_sleep_mode_select == MODE_IDLE)
                                       || (i_sleep_mode_select == MODE_ADC_NR)
                                       || (i_sleep_mode_select == MODE_PSAVE);
                        s_d.osc_en   = (i_sleep_mode_select == MODE_IDLE)
                                       || (i_sleep_mode_select == MODE_ADC_NR)
                                       || (i_sleep_mode_select == MODE_STANDBY);
                        s_d.tosc_en  = i_timer_async
                                       && ((i_sleep_mode_select == MODE_IDLE)
                                       || (i_sleep_mode_select == MODE_ADC_NR)
                                       || (i_sleep_mode_select == MODE_PSAVE));
                        s_d.adc_start = i_adc_enable
                                       && ((i_sleep_mode_select == MODE_IDLE)
                                       || (i_sleep_mode_select == MODE_ADC_NR));
                    end else begin
                        s_d.nop = 1'b1;
                    end
                end
            end
            ST_SLEEP: begin
                if (i_reset_req) begin
                    s_d.st       = ST_RUN;
                    s_d.wake_rst = 1'b1;
                end else if (wake_ok) begin
                    s_d.asleep   = 1'b0;
                    s_d.cpu_en   = 1'b1;
                    s_d.flash_en = 1'b1;
                    s_d.io_en    = 1'b1;
                    s_d.adc_en   = 1'b1;
                    s_d.asy_en   = 1'b1;
                    s_d.osc_en   = 1'b1;
                    s_d.tosc_en  = i_timer_async;
                    if (s_q.mode == MODE_STANDBY) begin
                        s_d.st       = ST_START;
                        s_d.wait_cnt = STANDBY_WAKE_CYC - 8'h01;
                    end else if ((s_q.mode == MODE_PDOWN) || (s_q.mode == MODE_PSAVE)) begin
                        s_d.st       = ST_START;
                        s_d.wait_cnt = PDOWN_WAKE_CYC - 8'h01;
                    end else begin
                        s_d.st       = ST_HOLD;
                        s_d.wait_cnt = STALL_CYC - 8'h01;
                    end
                end
            end
            ST_START: begin
                if (i_reset_req) begin
                    s_d.st       = ST_RUN;
                    s_d.stall    = 1'b0;
                    s_d.wake_rst = 1'b1;
                end else if (s_q.wait_cnt == RUNNING_WAKE_CYC) begin
                    s_d.st       = ST_HOLD;
                    s_d.wait_cnt = STALL_CYC - 8'h01;
                end else begin
                    s_d.wait_cnt = s_q.wait_cnt - 8'h01;
                end
            end
            ST_HOLD: begin
                if (i_reset_req) begin
                    s_d.st       = ST_RUN;
                    s_d.stall    = 1'b0;
                    s_d.wake_rst = 1'b1;
                end else if (s_q.wait_cnt == RUNNING_WAKE_CYC) begin
                    s_d.st       = ST_RUN;
                    s_d.stall    = 1'b0;
                    s_d.wake_irq = 1'b1;
                end else begin
                    s_d.wait_cnt = s_q.wait_cnt - 8'h01;
                end
            end
        endcase

        if (s_d.st == ST_RUN) begin
            s_d.asleep   = 1'b0;
            s_d.stall    = 1'b0;
            s_d.cpu_en   = 1'b1;
            s_d.flash_en = 1'b1;
            s_d.io_en    = 1'b1;
            s_d.adc_en   = 1'b1;
            s_d.asy_en   = 1'b1;
            s_d.osc_en   = 1'b1;
            s_d.tosc_en  = i_timer_async;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s_q          <= '0;
            s_q.div      <= DIV_RESET;
            s_q.pend_div <= DIV_RESET;
            s_q.cnt      <= CNT_RESET;
            s_q.st       <= ST_RUN;
            s_q.mode     <= MODE_RESET;
            s_q.cpu_en   <= 1'b1;
            s_q.flash_en <= 1'b1;
            s_q.io_en    <= 1'b1;
            s_q.adc_en   <= 1'b1;
            s_q.asy_en   <= 1'b1;
            s_q.osc_en   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_sys_clk_en   = s_q.tick;
    assign o_div_applied  = s_q.div;
    assign o_cpu_clk_en   = s_q.cpu_en;
    assign o_flash_clk_en = s_q.flash_en;
    assign o_io_clk_en    = s_q.io_en;
    assign o_adc_clk_en   = s_q.adc_en;
    assign o_async_clk_en = s_q.asy_en;
    assign o_main_osc_en  = s_q.osc_en;
    assign o_timer_osc_en = s_q.tosc_en;
    assign o_cpu_stall    = s_q.stall;
    assign o_asleep       = s_q.asleep;
    assign o_adc_start    = s_q.adc_start;
    assign o_wake_irq     = s_q.wake_irq;
    assign o_wake_reset   = s_q.wake_rst;
    assign o_sleep_nop    = s_q.nop;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    logic [8:0] gap_q;
    always_ff @(posedge i_mclk) begin
        if (i_rst || s_q.tick) begin
            gap_q <= 9'h000;
        end else if (gap_q != 9'h1ff) begin
            gap_q <= gap_q + 9'h001;
        end
    end

    div_no_fast_a: assert property (
        s_q.tick && $past(s_q.tick) |-> ($past(s_q.div) == 4'h0) || (s_q.div == 4'h0))
        else $error("divider produced a period shorter than both settings");
    div_switch_edge_a: assert property (
        $changed(s_q.div) |-> s_q.tick && (s_q.cnt == CNT_RESET))
        else $error("divider changed away from an old-rate edge");
    sleep_permit_a: assert property (
        (s_q.st == ST_RUN) && i_sleep_exec && !i_sleep_permit_bit |=> !s_q.asleep && s_q.nop)
        else $error("sleep entered without permit");
    nop_gate_a: assert property (
        s_q.nop |-> s_q.cpu_en && s_q.io_en && !s_q.stall)
        else $error("no-op sleep gated a clock");
    idle_clocks_a: assert property (
        (s_q.st == ST_SLEEP) && (s_q.mode == MODE_IDLE)
        |-> !s_q.cpu_en && !s_q.flash_en && s_q.io_en && s_q.adc_en && s_q.asy_en)
        else $error("idle clock set wrong");
    adc_clocks_a: assert property (
        (s_q.st == ST_SLEEP) && (s_q.mode == MODE_ADC_NR)
        |-> !s_q.io_en && s_q.adc_en && s_q.asy_en && s_q.osc_en)
        else $error("adc noise reduction clock set wrong");
    pdown_halt_a: assert property (
        (s_q.st == ST_SLEEP) && (s_q.mode == MODE_PDOWN)
        |-> !s_q.osc_en && !s_q.adc_en && !s_q.asy_en && !s_q.tosc_en)
        else $error("power-down left a clock running");
    idle_wake_stall_a: assert property (
        (s_q.st == ST_SLEEP) && (s_q.mode == MODE_IDLE) && !i_reset_req && i_irq_other_io
        |=> s_q.stall [*4] ##1 s_q.wake_irq && !s_q.stall)
        else $error("idle wake stall not four cycles");
    standby_wake_a: assert property (
        (s_q.st == ST_SLEEP) && (s_q.mode == MODE_STANDBY) && !i_reset_req && i_irq_pin_change
        |=> s_q.osc_en ##10 s_q.wake_irq)
        else $error("standby wake not six plus four cycles");
    reset_wake_a: assert property (
        (s_q.st == ST_SLEEP) && i_reset_req |=> s_q.wake_rst && !s_q.wake_irq && !s_q.asleep)
        else $error("reset during sleep did not wake to reset");
    edge_line0_a: assert property (
        (s_q.st == ST_SLEEP) && (s_q.mode == MODE_PDOWN) && !i_reset_req && i_irq_line_zero
        && !i_line_zero_level && !i_irq_pin_change && !i_irq_serial_start |=> s_q.asleep)
        else $error("edge-sensed line zero woke power-down");
    adc_start_a: assert property (
        (s_q.st == ST_RUN) && i_sleep_exec && i_sleep_permit_bit && i_adc_enable
        && (i_sleep_mode_select == MODE_ADC_NR) |=> s_q.adc_start)
        else $error("conversion not started on adc mode entry");
    tick_bound_a: assert property (
        gap_q <= 9'h100)
        else $error("divider edge missing");
    idle_wake_c: cover property (s_q.st == ST_HOLD ##1 s_q.wake_irq);
    div_change_c: cover property ($changed(s_q.div) && s_q.div == 4'h8);
    standby_c: cover property (s_q.st == ST_SLEEP && s_q.mode == MODE_STANDBY ##1 s_q.st == ST_START);
    reset_wake_c: cover property (s_q.wake_rst);

endmodule : sleep_mode_clock_gating

/* File: sim/wake_agent.sv */
`timescale 1ns/1ps
// ************************************************************
// wake sources: cpu-side peripherals raising level requests
// ************************************************************
module wake_agent (
    input  wire logic       i_mclk,
    input  wire logic       i_fire,
    input  wire logic [3:0] i_src,
    input  wire logic       i_clear,
    input  wire logic       i_woken,
    output logic [7:0]      o_irq,
    output logic            o_reset_req
);
    initial begin
        o_irq       = 8'h00;
        o_reset_req = 1'b0;
    end

    // a request stays up until the device reports the wake or i_clear is raised
    always @(negedge i_mclk) begin
        if (i_clear || i_woken) begin
            o_irq       <= 8'h00;
            o_reset_req <= 1'b0;
        end else if (i_fire) begin
            if (i_src == 4'h8) begin
                o_reset_req <= 1'b1;
            end else begin
                o_irq[i_src[2:0]] <= 1'b1;
            end
        end
    end
endmodule : wake_agent

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import sleep_clk_pkg::*;
    logic       i_mclk, i_rst, i_div_wr, i_sleep_exec, i_sleep_permit_bit, i_ext_crystal;
    logic       i_comparator_power_off, i_timer_async, i_adc_enable, i_line_zero_level;
    logic [3:0] i_clock_divide_select, src, cur_div, nv;
    logic [2:0] i_sleep_mode_select;
    logic [7:0] irq;
    logic       reset_req, fire, clear, o_sys_clk_en, o_cpu_clk_en, o_flash_clk_en;
    logic       o_io_clk_en, o_adc_clk_en, o_async_clk_en, o_main_osc_en, o_timer_osc_en;
    logic       o_cpu_stall, o_asleep, o_adc_start, o_wake_irq, o_wake_reset, o_sleep_nop;
    logic [3:0] o_div_applied;
    int         n_fail, compares, i, seed;
    logic [2:0] modes [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h4, 3'h5, 3'h7};

    sleep_mode_clock_gating sleep_mode_clock_gating_inst (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_div_wr(i_div_wr),
        .i_clock_divide_select(i_clock_divide_select), .i_sleep_exec(i_sleep_exec),
        .i_sleep_permit_bit(i_sleep_permit_bit), .i_sleep_mode_select(i_sleep_mode_select),
        .i_ext_crystal(i_ext_crystal), .i_comparator_power_off(i_comparator_power_off),
        .i_timer_async(i_timer_async), .i_adc_enable(i_adc_enable),
        .i_line_zero_level(i_line_zero_level),
        .i_reset_req(reset_req), .i_irq_line_zero(irq[0]), .i_irq_pin_change(irq[1]),
        .i_irq_serial_start(irq[2]), .i_irq_timer(irq[3]), .i_irq_mem_ready(irq[4]),
        .i_irq_adc_done(irq[5]), .i_irq_comparator(irq[6]), .i_irq_other_io(irq[7]),
        .o_sys_clk_en(o_sys_clk_en), .o_div_applied(o_div_applied),
        .o_cpu_clk_en(o_cpu_clk_en), .o_flash_clk_en(o_flash_clk_en),
        .o_io_clk_en(o_io_clk_en), .o_adc_clk_en(o_adc_clk_en),
        .o_async_clk_en(o_async_clk_en), .o_main_osc_en(o_main_osc_en),
        .o_timer_osc_en(o_timer_osc_en), .o_cpu_stall(o_cpu_stall), .o_asleep(o_asleep),
        .o_adc_start(o_adc_start), .o_wake_irq(o_wake_irq), .o_wake_reset(o_wake_reset),
        .o_sleep_nop(o_sleep_nop));
    wake_agent wake_agent_inst (.i_mclk(i_mclk), .i_fire(fire), .i_src(src), .i_clear(clear),
        .i_woken(o_wake_irq | o_wake_reset), .o_irq(irq), .o_reset_req(reset_req));

    always #5 i_mclk = ~i_mclk;

    // ************************************************************
    // expectations
    // ************************************************************
    function automatic logic [6:0] exp_en(input logic [2:0] m);
        logic [6:0] t;
        t = {6'h00, i_timer_async};
        case (m)
            MODE_IDLE:    return 7'h1e | t;
            MODE_ADC_NR:  return 7'h0e | t;
            MODE_PSAVE:   return 7'h04 | t;
            MODE_STANDBY: return 7'h02;
            default:      return 7'h00;
        endcase
    endfunction : exp_en

    function automatic logic wakes(input logic [2:0] m, input logic [3:0] s);
        logic deep;
        deep = (s inside {4'h1, 4'h2}) || (s == 4'h0 && i_line_zero_level);
        case (m)
            MODE_IDLE:   return (s != 4'h6) || !i_comparator_power_off;
            MODE_ADC_NR: return deep || (s inside {4'h4, 4'h5}) || (s == 4'h3 && i_timer_async);
            MODE_PSAVE:  return deep || (s == 4'h3 && i_timer_async);
            default:     return deep;
        endcase
    endfunction : wakes

    function automatic int hold_cyc(input logic [2:0] m);
        if (m == MODE_STANDBY) return STALL_CYC + STANDBY_WAKE_CYC;
        if (m == MODE_PDOWN || m == MODE_PSAVE) return STALL_CYC + PDOWN_WAKE_CYC;
        return STALL_CYC;
    endfunction : hold_cyc

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic div_test(input logic [3:0] v);
        int  cnt, ticks, gap, t;
        logic seen;
        @(negedge i_mclk);
        i_div_wr = 1'b1;
        i_clock_divide_select = v;
        @(negedge i_mclk);
        i_div_wr = 1'b0;
        if (v > DIV_MAX_LEGAL) begin
            repeat (600) @(posedge i_mclk);
            #1 chk(o_div_applied, cur_div);
            return;
        end
        seen = 1'b0;
        ticks = 0;
        for (cnt = 0; cnt < 600 && !seen; cnt++) begin
            @(posedge i_mclk);
            #1 seen = (o_div_applied === v);
            if (o_sys_clk_en && !seen) ticks++;
        end
        chk(seen, 1);
        chk(ticks <= 1, 1);
        chk(o_sys_clk_en, 1);
        for (t = 0; t < 2; t++) begin
            gap = 0;
            do begin
                @(posedge i_mclk);
                #1 gap++;
            end while (!o_sys_clk_en && gap < 600);
            chk(gap, 1 << v);
        end
        cur_div = v;
    endtask : div_test

    task automatic wait_wake(output logic w, output logic r, output int n);
        int k;
        w = 1'b0;
        r = 1'b0;
        n = 0;
        for (k = 0; k < 40 && !w; k++) begin
            @(posedge i_mclk);
            #1 if (o_cpu_stall && !o_asleep) n++;
            r = o_wake_reset;
            w = o_wake_irq || o_wake_reset;
        end
    endtask : wait_wake

    task automatic raise(input logic [3:0] s);
        @(negedge i_mclk);
        clear <= 1'b0;
        fire <= 1'b1;
        src <= s;
        @(negedge i_mclk);
        fire <= 1'b0;
    endtask : raise

    task automatic sleep_once(input logic [2:0] m, input logic [3:0] s);
        logic ok, sn, st, w, r;
        int   n;
        // standby is only legal with the crystal; without it the request must be refused
        ok = i_sleep_permit_bit && (m < 3'h4 || (m == MODE_STANDBY && i_ext_crystal));
        @(negedge i_mclk);
        i_sleep_mode_select <= m;
        i_sleep_exec <= 1'b1;
        @(posedge i_mclk);
        // nop and conversion start stand only in the cycle right after the request
        #1 sn = o_sleep_nop;
        st = o_adc_start;
        @(negedge i_mclk);
        i_sleep_exec <= 1'b0;
        repeat (2) begin
            @(posedge i_mclk);
            #1 sn |= o_sleep_nop;
            st |= o_adc_start;
        end
        chk(o_asleep, ok);
        chk(sn, !ok);
        if (!ok) begin
            chk({o_cpu_clk_en, o_flash_clk_en, o_io_clk_en, o_adc_clk_en, o_async_clk_en,
                 o_main_osc_en}, 6'h3f);
            return;
        end
        chk(st, i_adc_enable && m < 3'h2);
        chk({o_cpu_clk_en, o_flash_clk_en, o_io_clk_en, o_adc_clk_en, o_async_clk_en,
             o_main_osc_en, o_timer_osc_en}, exp_en(m));
        chk(o_cpu_stall, 1);
        raise(s);
        wait_wake(w, r, n);
        if (s == 4'h8) chk({w, r}, 2'h3);
        else chk(w, wakes(m, s));
        if (w && !r) chk(n, hold_cyc(m));
        if (!w) begin
            chk(o_asleep, 1);
            @(negedge i_mclk);
            clear <= 1'b1;
            raise(4'h1);
            wait_wake(w, r, n);
            chk({w, r}, 2'h2);
            chk(n, hold_cyc(m));
        end
        repeat (2) @(posedge i_mclk);
        #1 chk({o_cpu_clk_en, o_flash_clk_en, o_asleep, o_cpu_stall}, 4'hc);
    endtask : sleep_once

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        {i_mclk, i_div_wr, i_sleep_exec, i_ext_crystal, i_comparator_power_off} = 5'h00;
        {i_timer_async, i_adc_enable, i_line_zero_level, fire, clear} = 5'h00;
        {i_rst, i_sleep_permit_bit} = 2'h3;
        i_clock_divide_select = 4'h0;
        i_sleep_mode_select = 3'h0;
        src = 4'h0;
        cur_div = DIV_RESET;
        n_fail = 0;
        compares = 0;
        seed = $urandom(77908);
        repeat (20) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rst = 1'b0;
        @(posedge i_mclk);
        #1 chk({o_cpu_clk_en, o_flash_clk_en, o_io_clk_en, o_adc_clk_en, o_async_clk_en,
                o_main_osc_en, o_timer_osc_en, o_asleep, o_cpu_stall}, 9'h1f8);
        chk(o_div_applied, DIV_RESET);
        div_test(4'h1);
        div_test(4'h9);
        div_test(4'h8);
        for (i = 0; i < 5; i++) begin
            nv = 4'((cur_div + 1 + $urandom_range(0, 7)) % 9);
            div_test(nv);
        end
        div_test(4'h0);
        sleep_once(MODE_PDOWN, 4'h8);
        @(negedge i_mclk);
        i_ext_crystal = 1'b1;
        sleep_once(MODE_STANDBY, 4'h1);
        sleep_once(MODE_IDLE, 4'h7);
        sleep_once(MODE_PDOWN, 4'h0);
        for (i = 0; i < 48; i++) begin
            @(negedge i_mclk);
            i_sleep_permit_bit = ($urandom_range(0, 5) != 0);
            {i_ext_crystal, i_comparator_power_off, i_timer_async} = 3'($urandom);
            {i_adc_enable, i_line_zero_level} = 2'($urandom);
            sleep_once(modes[i % 8], 4'($urandom_range(0, 8)));
        end
        stop_test();
    end

    initial begin
        #300000;
        n_fail++;
        stop_test();
    end
endmodule : testbench
